// *** pure_pkg.sv ***
package pure_pkg;
    localparam int CMD_W = 15;
    localparam int STRAP_W = 6;
    localparam int RATIO_W = 4;
    localparam int SYNC_STAGES = 5;
    // command codes on the active-low command bus, values arbitrary
    localparam logic [14:0] CMD_NZ_IDLE = 15'h7ffe;
    localparam logic [14:0] CMD_NOP = 15'h7fff;
    localparam logic [14:0] CMD_RESET_VAL = 15'h7fff;
    // strap bit positions
    localparam int STRAP_RATIO_LSB = 0;
    localparam int STRAP_FRAME_MODE_BIT = 5;
    localparam int STRAP_FWD_SAMPLE_BIT = 4;
    // divisor encoding
    localparam logic [3:0] RATIO_CODE_EIGHT = 4'h0;
    localparam logic [4:0] RATIO_EIGHT = 5'h08;
    // phase lengths in core cycles
    localparam int CLK_LOAD_CYCLES = 4;
    localparam int RAMP_CYCLES = 16;
    localparam int SELF_TEST_CYCLES = 32;
    localparam int ROM_LOAD_CYCLES = 32;
    localparam int CNT_W = 8;
    localparam logic [7:0] CNT_ZERO = 8'h00;

    typedef enum logic [2:0] {
        ST_SUPPLY_SETTLE = 3'b000,
        ST_RESET_WAIT = 3'b001,
        ST_CLK_LOAD = 3'b010,
        ST_RAMP = 3'b011,
        ST_SELF_TEST = 3'b100,
        ST_ROM_LOAD = 3'b101,
        ST_RUN = 3'b110
    } pure_state_t;

    typedef struct packed {
        logic frame_copy_mode;
        logic fwd_sample_internal;
        logic [4:0] clock_ratio_divisor;
    } pure_cfg_t;

    typedef struct packed {
        logic pll_charge_pump_en;
        logic array_self_test_run;
        logic boot_serial_rom_load;
        logic core_reset;
        logic run;
    } pure_status_t;
endpackage

// *** pure_power_up_reset_entry.sv ***
`timescale 1ns/1ps
// Summary of operation
// R1 - power-up leaves command bus undefined; other resets keep its previous value; code loads CMD_RESET_VAL on cold reset, keeps the bus on warm reset
// R2 - after forwarded-clock reset drive nonzero idle, then no-op once running
// R3 - system holds reset asserted while supplies ramp
// R4 - system keeps power-good low until supplies settle, then raises it
// R5 - before power-good, internal logic held in reset while clock runs
// R6 - wait in supply-settle state until power-good seen
// R7 - power-good lets the sequence advance past supply-settle
// R8 - power-good latches straps and divisor and enables charge pump
// R9 - divisor codes 0011-0111 give 3-7, 0000 gives 8, 1xxx gives 9 up
// R10 - reset deassertion passes five synchroniser stages before use
// R11 - after reset: clock load, ramp, self-test, then rom load
// R12 - leave supply-settle only after power-good and straps captured
module pure_power_up_reset_entry (
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_in_n,
    input wire logic power_good_in,
    input wire logic cold_reset,
    input wire logic loop_bypass_select,
    input wire logic forwarded_clock_reset_in,
    input wire logic [pure_pkg::STRAP_W-1:0] strap_in,
    output logic [pure_pkg::CMD_W-1:0] system_command_out_bus,
    output logic clock_source_bypass,
    output pure_pkg::pure_cfg_t cfg,
    output pure_pkg::pure_status_t status
);
    import pure_pkg::*;

    ////////////////////////////////////////////////////////////////
    pure_state_t state_q, state_d;
    logic [SYNC_STAGES-1:0] sync_q;
    logic pg_seen_q, cap_done_q, pump_q, fwd_done_q;
    pure_cfg_t cfg_q;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CMD_W-1:0] cmd_q, cmd_d;
    logic [4:0] ratio_dec;
    logic [3:0] ratio_code;
    logic reset_sync_n, phase_done;

    // five stage synchroniser of reset input
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_q <= '0;
        end else begin
            sync_q <= {sync_q[SYNC_STAGES-2:0], reset_in_n}; // R10
        end
    end
    assign reset_sync_n = sync_q[SYNC_STAGES-1]; // R10

    // divisor decode
    assign ratio_code = strap_in[STRAP_RATIO_LSB +: RATIO_W];
    assign ratio_dec = (ratio_code == RATIO_CODE_EIGHT) ? RATIO_EIGHT :
        {1'b0, ratio_code} + ((ratio_code[3]) ? 5'h01 : 5'h00); // R9

    // strap capture on power-good
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pg_seen_q <= 1'b0;
            cap_done_q <= 1'b0;
            pump_q <= 1'b0;
            cfg_q <= '0;
        end else if (power_good_in && !pg_seen_q) begin
            pg_seen_q <= 1'b1;
            cap_done_q <= 1'b1; // R8
            pump_q <= 1'b1; // R8
            cfg_q.clock_ratio_divisor <= ratio_dec; // R8 R9
            cfg_q.frame_copy_mode <= strap_in[STRAP_FRAME_MODE_BIT];
            cfg_q.fwd_sample_internal <= strap_in[STRAP_FWD_SAMPLE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////
    assign phase_done = (cnt_q == CNT_ZERO);

    always_comb begin
        state_d = state_q;
        cnt_d = phase_done ? cnt_q : cnt_q - 8'h01;
        unique case (state_q)
            ST_SUPPLY_SETTLE: begin
                if (pg_seen_q && cap_done_q) begin // R6 R7 R12
                    state_d = ST_RESET_WAIT;
                end
            end
            ST_RESET_WAIT: begin
                if (reset_sync_n) begin // R10
                    state_d = ST_CLK_LOAD;
                    cnt_d = CNT_W'(CLK_LOAD_CYCLES - 1);
                end
            end
            ST_CLK_LOAD: begin
                if (phase_done) begin // R11
                    state_d = ST_RAMP;
                    cnt_d = CNT_W'(RAMP_CYCLES - 1);
                end
            end
            ST_RAMP: begin
                if (phase_done) begin // R11
                    state_d = ST_SELF_TEST;
                    cnt_d = CNT_W'(SELF_TEST_CYCLES - 1);
                end
            end
            ST_SELF_TEST: begin
                if (phase_done) begin // R11
                    state_d = ST_ROM_LOAD;
                    cnt_d = CNT_W'(ROM_LOAD_CYCLES - 1);
                end
            end
            ST_ROM_LOAD: begin
                if (phase_done) begin // R11
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
            end
            default: begin
                state_d = ST_SUPPLY_SETTLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_SUPPLY_SETTLE; // R5 R6
            cnt_q <= CNT_ZERO;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // command bus behaviour across reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fwd_done_q <= 1'b0;
        end else if (forwarded_clock_reset_in && state_q != ST_SUPPLY_SETTLE) begin
            fwd_done_q <= 1'b1;
        end
    end

    always_comb begin
        cmd_d = cmd_q; // R1
        if (state_q == ST_RUN) begin
            cmd_d = CMD_NOP; // R2
        end else if (fwd_done_q) begin
            cmd_d = CMD_NZ_IDLE; // R2
        end
    end

    // cold reset reloads a fixed value; warm reset keeps the bus
    always_ff @(posedge clk) begin
        if (rst && cold_reset) begin
            cmd_q <= CMD_RESET_VAL; // R1
        end else if (!rst) begin
            cmd_q <= cmd_d;
        end
    end

    assign system_command_out_bus = cmd_q;
    assign clock_source_bypass = !loop_bypass_select; // R5
    assign cfg = cfg_q;
    assign status = '{
        pll_charge_pump_en: pump_q, // R8
        array_self_test_run: (state_q == ST_SELF_TEST), // R11
        boot_serial_rom_load: (state_q == ST_ROM_LOAD), // R11
        core_reset: (state_q == ST_SUPPLY_SETTLE) || (state_q == ST_RESET_WAIT), // R5
        run: (state_q == ST_RUN)
    };

    ////////////////////////////////////////////////////////////////
    sequence s_self_test_end;
        state_q == ST_SELF_TEST ##1 state_q == ST_ROM_LOAD;
    endsequence

    chk_settle_hold: assert property (@(posedge clk) disable iff (rst) // R6
        (state_q == ST_SUPPLY_SETTLE && !pg_seen_q) |=> state_q == ST_SUPPLY_SETTLE)
        else $error("left settle without power-good");
    chk_settle_exit: assert property (@(posedge clk) disable iff (rst) // R7
        (state_q == ST_SUPPLY_SETTLE && pg_seen_q) |=> state_q == ST_RESET_WAIT)
        else $error("settle exit missing");
    chk_strap_capture: assert property (@(posedge clk) disable iff (rst) // R8
        (power_good_in && !pg_seen_q) |=> pump_q && cfg_q.clock_ratio_divisor == $past(ratio_dec))
        else $error("straps not latched");
    chk_ratio_decode: assert property (@(posedge clk) disable iff (rst) // R9
        (ratio_code == 4'h3 |-> ratio_dec == 5'h03) and (ratio_code == 4'h8 |-> ratio_dec == 5'h09))
        else $error("divisor decode wrong");
    chk_sync_depth: assert property (@(posedge clk) disable iff (rst) // R10
        (state_q == ST_RESET_WAIT && !reset_in_n) |=> state_q == ST_RESET_WAIT [*4])
        else $error("reset passed synchroniser early");
    chk_phase_order: assert property (@(posedge clk) disable iff (rst) // R11
        s_self_test_end |-> $past(phase_done) && cnt_q == CNT_W'(ROM_LOAD_CYCLES - 1))
        else $error("self-test to rom order wrong");
    chk_run_nop: assert property (@(posedge clk) disable iff (rst) // R2
        state_q == ST_RUN |=> system_command_out_bus == CMD_NOP)
        else $error("no-op not driven in run");
    chk_idle_cmd: assert property (@(posedge clk) disable iff (rst) // R2
        (fwd_done_q && state_q != ST_RUN) |=> system_command_out_bus == CMD_NZ_IDLE)
        else $error("idle command missing");
    chk_core_reset: assert property (@(posedge clk) disable iff (rst) // R5
        !pg_seen_q |-> status.core_reset)
        else $error("core left reset before power-good");
    chk_pg_gate: assert property (@(posedge clk) disable iff (rst) // R12
        $rose(state_q == ST_RESET_WAIT) |-> cap_done_q)
        else $error("settle left before capture");
endmodule // pure_power_up_reset_entry

// *** pure_board_model.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// board reset and power control model
module pure_board_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic supply_ok,
    input wire logic release_req,
    input wire logic fwd_req,
    output logic power_good_in,
    output logic reset_in_n,
    output logic forwarded_clock_reset_in
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            power_good_in <= 1'b0;
            reset_in_n <= 1'b0;
            forwarded_clock_reset_in <= 1'b0;
        end else begin
            power_good_in <= supply_ok;
            reset_in_n <= release_req & power_good_in;
            forwarded_clock_reset_in <= fwd_req & reset_in_n;
        end
    end
endmodule // pure_board_model

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import pure_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cold_reset = 1'b1;
    logic loop_bypass_select = 1'b1;
    logic supply_ok = 1'b0;
    logic release_req = 1'b0;
    logic fwd_req = 1'b0;
    logic [STRAP_W-1:0] strap_in = '0;
    logic reset_in_n, power_good_in, forwarded_clock_reset_in, clock_source_bypass;
    logic [CMD_W-1:0] system_command_out_bus;
    pure_cfg_t cfg;
    pure_status_t status;
    int bad_count = 0;
    int n_tests = 0;
    always #2.5 clk = ~clk;
    pure_power_up_reset_entry u_pure_power_up_reset_entry (.clk(clk), .rst(rst),
        .reset_in_n(reset_in_n), .power_good_in(power_good_in), .cold_reset(cold_reset),
        .loop_bypass_select(loop_bypass_select), .strap_in(strap_in),
        .forwarded_clock_reset_in(forwarded_clock_reset_in), .cfg(cfg), .status(status),
        .system_command_out_bus(system_command_out_bus),
        .clock_source_bypass(clock_source_bypass));
    pure_board_model u_pure_board_model (.clk(clk), .rst(rst), .supply_ok(supply_ok),
        .release_req(release_req), .fwd_req(fwd_req), .power_good_in(power_good_in),
        .reset_in_n(reset_in_n), .forwarded_clock_reset_in(forwarded_clock_reset_in));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [14:0] seen, input logic [14:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [4:0] exp_div(input logic [3:0] c);
        if (c == 4'h0) return 5'h08;
        return c[3] ? 5'(c) + 5'h01 : 5'(c);
    endfunction
    task automatic do_rst(input logic cold);
        @(posedge clk);
        rst <= 1'b1;
        cold_reset <= cold;
        supply_ok <= 1'b0;
        release_req <= 1'b0;
        fwd_req <= 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic wait_bit(input int b, output int n);
        n = 0;
        while (status[b] !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_settle;
        do_rst(1'b1);
        fwd_req <= 1'b1;
        release_req <= 1'b1;
        repeat (20) @(posedge clk);
        #1;
        chk(15'(status.core_reset), 15'h1);
        chk(15'(status.pll_charge_pump_en), 15'h0);
        chk(15'(status.run), 15'h0);
        chk(system_command_out_bus, CMD_RESET_VAL);
        chk(15'(clock_source_bypass), 15'h0);
        @(posedge clk);
        loop_bypass_select <= 1'b0;
        @(posedge clk);
        #1;
        chk(15'(clock_source_bypass), 15'h1);
        @(posedge clk);
        loop_bypass_select <= 1'b1;
        $display("settle test done");
    endtask
    task automatic t_seq(input logic [5:0] s, input logic warm);
        int n;
        do_rst(1'b1);
        strap_in <= s;
        supply_ok <= 1'b1;
        wait (power_good_in === 1'b1);
        @(posedge clk);
        #1;
        chk(15'(status.pll_charge_pump_en), 15'h1);
        chk(15'(cfg), {8'h00, s[5], s[4], exp_div(s[3:0])});
        @(posedge clk);
        strap_in <= ~s;
        release_req <= 1'b1;
        fwd_req <= 1'b1;
        wait (reset_in_n === 1'b1);
        wait_bit(3, n);
        chk(15'(n >= SYNC_STAGES + CLK_LOAD_CYCLES + RAMP_CYCLES && n <= 27), 15'h1);
        chk(system_command_out_bus, CMD_NZ_IDLE);
        chk(15'(cfg), {8'h00, s[5], s[4], exp_div(s[3:0])});
        if (warm) begin
            do_rst(1'b0);
            #1;
            chk(system_command_out_bus, CMD_NZ_IDLE);
            do_rst(1'b1);
            #1;
            chk(system_command_out_bus, CMD_RESET_VAL);
        end else begin
            wait_bit(2, n);
            chk(15'(n), 15'(SELF_TEST_CYCLES));
            wait_bit(0, n);
            chk(15'(n), 15'(ROM_LOAD_CYCLES));
            @(posedge clk);
            #1;
            chk(system_command_out_bus, CMD_NOP);
        end
        $display("sequence test done strap %h", s);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_settle;
        t_seq(6'h03, 1'b0);
        t_seq(6'h17, 1'b0);
        t_seq(6'h20, 1'b0);
        t_seq(6'h38, 1'b0);
        t_seq(6'h3f, 1'b0);
        t_seq(6'h14, 1'b1);
        final_report;
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        final_report;
    end
endmodule // tb_top
